// File: src/pmp_pkg.sv
// shared constants, carrier structs and state codes of the phy mii port
package pmp_pkg;
   // -------------------------------------------------------------------
   // clocking
   // -------------------------------------------------------------------
   localparam int CLK_MHZ    = 100;                  // system clock rate
   localparam int REF_MHZ    = 25;                   // fast mii clock rate
   localparam int SLOW_RATIO = 10;                   // 25 MHz / 2.5 MHz
   localparam int DIV_FAST   = CLK_MHZ / REF_MHZ;    // cycles per 25 MHz period
   localparam int DIV_SLOW   = DIV_FAST * SLOW_RATIO; // cycles per 2.5 MHz period
   localparam int DIV_W      = $clog2(DIV_SLOW);
   localparam logic [DIV_W-1:0] DIV_RST = '0;

   // -------------------------------------------------------------------
   // heartbeat
   // -------------------------------------------------------------------
   localparam int HB_NS  = 1000;                     // sqe pulse, about 1 us
   localparam int HB_CYC = (HB_NS * CLK_MHZ + 999) / 1000;
   localparam int HB_W   = $clog2(HB_CYC + 1);

   // -------------------------------------------------------------------
   // management frame
   // -------------------------------------------------------------------
   localparam int PRE_BITS  = 32;                    // preamble ones
   localparam int HDR_BITS  = 13;                    // start bit 2, op, phy, reg
   localparam int DATA_BITS = 16;
   localparam int MCNT_W    = 6;
   localparam int HDR_START = 12;                    // second start bit position
   localparam int HDR_OP    = 10;                    // op field low bit
   localparam int HDR_PHY   = 5;                     // phy address low bit
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [DATA_BITS-1:0] STAT_RST = 16'h0000;

   // line side receive word: nibble and invalid code flag
   typedef struct packed {
      logic       err;
      logic [3:0] nib;
   } pmp_rx_word_t;

   // line side transmit word: nibble and halt substitution
   typedef struct packed {
      logic       halt;
      logic [3:0] nib;
   } pmp_tx_word_t;

   // management engine states
   typedef enum logic [3:0] {
      MS_PRE  = 4'h1,
      MS_HDR  = 4'h2,
      MS_TA   = 4'h4,
      MS_DATA = 4'h8
   } pmp_mstate_t;
endpackage : pmp_pkg

// File: src/pmp_port.sv
// phy side mii port: clocks, carrier, collision, data paths and management
//
// How it works
// R1: management clock from the manager stays at or below 25 MHz.
// R2: management clock and data are synchronised, any phase works at rates up to 25 MHz.
// R3: management data is open drain, driven low only while answering.
// R4: half duplex: carrier sense follows receive or transmit activity.
// R5: full duplex: carrier sense follows receive activity only.
// R6: half duplex: collision while transmit and receive overlap.
// R7: 10 Mb/s half duplex with heartbeat: 1 us collision after transmit.
// R8: full duplex: collision always low, no heartbeat.
// R9: transmit clock 25 MHz or 2.5 MHz divided from the 100 MHz system clock.
// R10: mac presents transmit nibbles synchronous to the transmit clock.
// R11: mac holds transmit enable exactly while nibbles are valid.
// R12: 100 Mb/s: transmit error with enable sends halt instead of data.
// R13: 10 Mb/s: transmit error is ignored entirely.
// R14: receive clock 25 MHz or 2.5 MHz.
// R15: receive nibbles change on the falling receive clock edge.
// R16: 100 Mb/s: receive error marks an invalid code group.
// R17: receive data valid marks nibbles, updated on the falling edge.
// R18: in reset or without link, status outputs stay low.
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// receive buffer
// ----------------------------------------------------------------------
module pmp_fifo #(
   parameter int W     = 5,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic         clock_in,
   input  wire logic         rst_n_in,
   // fill side
   input  wire logic [W-1:0] in_data_in,
   input  wire logic         in_valid_in,
   output logic              in_ready_out,
   // drain side
   output logic [W-1:0]      out_data_out,
   output logic              out_valid_out,
   input  wire logic         out_ready_in
);
   localparam int AW = $clog2(DEPTH);

   // refuse depths that the wrapping pointers cannot serve
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("depth must be a power of two");
   end

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [AW:0]             cnt;
      logic                    room;
   } pmp_fifo_st_t;

   pmp_fifo_st_t st;
   pmp_fifo_st_t next_st;
   logic         push;
   logic         pop;

   // push and pop bookkeeping, room kept in a flop
   always_comb begin
      next_st = st;
      push = in_valid_in && st.room;
      pop = out_ready_in && (st.cnt != '0);
      if (push) begin
         next_st.mem[st.wp] = in_data_in;
         next_st.wp = st.wp + 1'b1;
      end
      if (pop) next_st.rp = st.rp + 1'b1;
      next_st.cnt = st.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      next_st.room = (next_st.cnt != DEPTH[AW:0]);
   end

   // state register
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st <= '0;
         st.room <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign in_ready_out  = st.room;
   assign out_valid_out = (st.cnt != '0);
   assign out_data_out  = st.mem[st.rp];
endmodule : pmp_fifo

// ----------------------------------------------------------------------
// port top
// ----------------------------------------------------------------------
module pmp_port #(
   parameter int RX_DEPTH = 8
) (
   // clock and reset
   input  wire logic                  clock_in,
   input  wire logic                  rst_n_in,
   // mode
   input  wire logic                  speed_100_in,
   input  wire logic                  full_duplex_in,
   input  wire logic                  link_up_in,
   input  wire logic                  heartbeat_en_in,
   input  wire logic [4:0]            phy_addr_in,
   // mac transmit
   input  wire logic [3:0]            txd_in,
   input  wire logic                  tx_en_in,
   input  wire logic                  tx_er_in,
   output logic                       tx_clk_out,
   // mac receive and status
   output logic [3:0]                 rxd_out,
   output logic                       rx_dv_out,
   output logic                       rx_er_out,
   output logic                       rx_clk_out,
   output logic                       crs_out,
   output logic                       col_out,
   // management
   input  wire logic                  mdc_in,
   input  wire logic                  mdio_in,
   output logic                       mdio_out,
   output logic                       mdio_oe_out,
   // line transmit
   output pmp_pkg::pmp_tx_word_t      tx_word_out,
   output logic                       tx_valid_out,
   // line receive
   input  wire pmp_pkg::pmp_rx_word_t rx_word_in,
   input  wire logic                  rx_valid_in,
   output logic                       rx_ready_out,
   input  wire logic                  rx_carrier_in
);
   // refuse a receive buffer too small to decouple line and mii
   if (RX_DEPTH < 2) begin : g_bad_rx_depth
      $error("receive buffer too small");
   end

   typedef struct packed {
      logic [pmp_pkg::DIV_W-1:0]     div;
      logic                          mclk;
      logic [2:0]                    mdc_s;
      logic [2:0]                    mdio_s;
      logic                          mdc_lvl;
      logic                          mdio_lvl;
      pmp_pkg::pmp_mstate_t          ms;
      logic [pmp_pkg::MCNT_W-1:0]    mcnt;
      logic [pmp_pkg::HDR_BITS-2:0]  hdr;
      logic                          rd;
      logic [pmp_pkg::DATA_BITS-1:0] msh;
      logic                          md_oe;
      logic                          tx_act;
      logic [pmp_pkg::HB_W-1:0]      hb;
      pmp_pkg::pmp_tx_word_t         txw;
      logic                          txv;
      logic [3:0]                    rxd;
      logic                          rxdv;
      logic                          rxer;
      logic                          crs;
      logic                          col;
   } pmp_st_t;

   pmp_st_t                  st;
   pmp_st_t                  next_st;
   logic [pmp_pkg::DIV_W-1:0] period;
   logic                     rise_en;
   logic                     fall_en;
   logic                     half;
   logic                     mdc_n;
   logic                     mdio_n;
   logic                     mrise;
   logic [pmp_pkg::HDR_BITS-1:0] hword;
   pmp_pkg::pmp_rx_word_t    f_data;
   logic                     f_valid;
   logic [pmp_pkg::DATA_BITS-1:0] stat_word;

   // receive buffer between line and mii
   pmp_fifo #(
      .W     ($bits(pmp_pkg::pmp_rx_word_t)),
      .DEPTH (RX_DEPTH)
   ) u_rx_fifo (
      .clock_in      (clock_in),
      .rst_n_in      (rst_n_in),
      .in_data_in    (rx_word_in),
      .in_valid_in   (rx_valid_in),
      .in_ready_out  (rx_ready_out),
      .out_data_out  (f_data),
      .out_valid_out (f_valid),
      .out_ready_in  (fall_en)
   );

   // clock divider enables
   always_comb begin
      period = speed_100_in ? pmp_pkg::DIV_FAST[pmp_pkg::DIV_W-1:0]
                            : pmp_pkg::DIV_SLOW[pmp_pkg::DIV_W-1:0];
      rise_en = (st.div >= period - 1'b1);
      fall_en = st.mclk & (st.div == (period >> 1) - 1'b1);
      half = ~speed_100_in & ~full_duplex_in;
   end

   // status word returned on management reads
   assign stat_word = pmp_pkg::STAT_RST |
                      {12'h000, heartbeat_en_in, full_duplex_in, speed_100_in, link_up_in};

   // next state of the whole port
   always_comb begin
      next_st = st;
      // mii clocks, rising only on a sampling cycle so that a speed change
      // never shows the mac an edge that takes no nibble
      next_st.div = rise_en ? pmp_pkg::DIV_RST : st.div + 1'b1;               // R9 R14
      next_st.mclk = rise_en | (st.mclk & (next_st.div < (period >> 1)));   // R9 R14
      // transmit sampling on the rising mii clock edge
      if (rise_en) begin
         next_st.tx_act = tx_en_in;
         next_st.txv = tx_en_in;
         next_st.txw.nib = txd_in;
         next_st.txw.halt = speed_100_in & tx_en_in & tx_er_in;              // R12 R13
      end
      // heartbeat after the end of a 10 Mb/s half duplex transmission
      if (st.hb != '0) next_st.hb = st.hb - 1'b1;
      if (rise_en && st.tx_act && !tx_en_in && half && heartbeat_en_in && link_up_in)
         next_st.hb = pmp_pkg::HB_CYC[pmp_pkg::HB_W-1:0];                    // R7
      if (full_duplex_in || !link_up_in) next_st.hb = '0;                    // R8
      // carrier and collision
      next_st.crs = link_up_in &
                    (rx_carrier_in | (next_st.tx_act & ~full_duplex_in));    // R4 R5 R18
      next_st.col = link_up_in & ~full_duplex_in &
                    ((next_st.tx_act & rx_carrier_in) | (next_st.hb != '0)); // R6 R7 R8 R18
      // receive nibbles leave on the falling mii clock edge
      if (fall_en) begin
         next_st.rxdv = link_up_in & f_valid;                                 // R17 R18
         next_st.rxd = f_valid ? f_data.nib : 4'h0;                           // R15
         next_st.rxer = link_up_in & f_valid & speed_100_in & f_data.err;    // R16
      end
      if (!link_up_in) begin
         next_st.rxdv = 1'b0;                                                 // R18
         next_st.rxer = 1'b0;
      end
      // management synchroniser and filter
      next_st.mdc_s = {st.mdc_s[1:0], mdc_in};                               // R2
      next_st.mdio_s = {st.mdio_s[1:0], mdio_in};
      mdc_n = (st.mdc_s[1] == st.mdc_s[2]) ? st.mdc_s[2] : st.mdc_lvl;
      mdio_n = (st.mdio_s[1] == st.mdio_s[2]) ? st.mdio_s[2] : st.mdio_lvl;
      next_st.mdc_lvl = mdc_n;
      next_st.mdio_lvl = mdio_n;
      hword = {st.hdr, mdio_n};
      mrise = mdc_n & ~st.mdc_lvl;
      // management frame engine, one step per management clock rise
      if (mrise) begin
         case (st.ms)
            pmp_pkg::MS_PRE: begin
               if (mdio_n) begin
                  if (st.mcnt < pmp_pkg::PRE_BITS[pmp_pkg::MCNT_W-1:0])
                     next_st.mcnt = st.mcnt + 1'b1;
               end else if (st.mcnt == pmp_pkg::PRE_BITS[pmp_pkg::MCNT_W-1:0]) begin
                  next_st.ms = pmp_pkg::MS_HDR;
                  next_st.mcnt = '0;
               end else begin
                  next_st.mcnt = '0;
               end
            end
            pmp_pkg::MS_HDR: begin
               next_st.hdr = hword[pmp_pkg::HDR_BITS-2:0];
               next_st.mcnt = st.mcnt + 1'b1;
               if (st.mcnt == pmp_pkg::MCNT_W'(pmp_pkg::HDR_BITS - 1)) begin
                  next_st.mcnt = '0;
                  next_st.ms = hword[pmp_pkg::HDR_START] ? pmp_pkg::MS_TA
                                                         : pmp_pkg::MS_PRE;
                  next_st.rd = (hword[pmp_pkg::HDR_OP +: 2] == pmp_pkg::OP_READ) &&
                               (hword[pmp_pkg::HDR_PHY +: 5] == phy_addr_in);
               end
            end
            pmp_pkg::MS_TA: begin
               next_st.md_oe = st.rd;                                         // R3
               next_st.msh = stat_word;
               next_st.ms = pmp_pkg::MS_DATA;
            end
            pmp_pkg::MS_DATA: begin
               if (st.mcnt == pmp_pkg::DATA_BITS[pmp_pkg::MCNT_W-1:0]) begin
                  next_st.md_oe = 1'b0;                                       // R3
                  next_st.rd = 1'b0;
                  next_st.mcnt = '0;
                  next_st.ms = pmp_pkg::MS_PRE;
               end else begin
                  next_st.md_oe = st.rd & ~st.msh[pmp_pkg::DATA_BITS-1];     // R3
                  next_st.msh = {st.msh[pmp_pkg::DATA_BITS-2:0], 1'b0};
                  next_st.mcnt = st.mcnt + 1'b1;
               end
            end
            default: begin
               next_st.ms = pmp_pkg::MS_PRE;
               next_st.md_oe = 1'b0;
               next_st.mcnt = '0;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st <= '0;                                                             // R18
         st.ms <= pmp_pkg::MS_PRE;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state flops, except mdio_out, which is tied low
   assign tx_clk_out   = st.mclk;
   assign rx_clk_out   = st.mclk;
   assign rxd_out      = st.rxd;
   assign rx_dv_out    = st.rxdv;
   assign rx_er_out    = st.rxer;
   assign crs_out      = st.crs;
   assign col_out      = st.col;
   assign mdio_out     = 1'b0;       // open drain: only ever pulls low
   assign mdio_oe_out  = st.md_oe;
   assign tx_word_out  = st.txw;
   assign tx_valid_out = st.txv;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);

   property p_crs_half;
      (link_up_in && !full_duplex_in && rx_carrier_in) |=> crs_out;
   endproperty
   a_crs_half: assert property (p_crs_half) else $error("crs missed"); // R4

   property p_crs_full;
      (full_duplex_in && !rx_carrier_in) |=> !crs_out;
   endproperty
   a_crs_full: assert property (p_crs_full) else $error("crs from tx"); // R5

   property p_col;
      (link_up_in && !full_duplex_in && next_st.tx_act && rx_carrier_in) |=> col_out;
   endproperty
   a_col: assert property (p_col) else $error("collision missed"); // R6

   property p_hb;
      (rise_en && st.tx_act && !tx_en_in && half && heartbeat_en_in && link_up_in)
         ##1 (link_up_in && !full_duplex_in)[*2] |=> col_out[*8];
   endproperty
   a_hb: assert property (p_hb) else $error("heartbeat missing"); // R7

   property p_fd_col;
      full_duplex_in |=> !col_out;
   endproperty
   a_fd_col: assert property (p_fd_col) else $error("collision in full duplex"); // R8

   property p_clk_fast;
      ($rose(tx_clk_out) ##0 speed_100_in[*2]) |=> !tx_clk_out;
   endproperty
   a_clk_fast: assert property (p_clk_fast) else $error("fast clock period"); // R9

   property p_halt;
      (rise_en && speed_100_in && tx_en_in && tx_er_in) |=> tx_word_out.halt;
   endproperty
   a_halt: assert property (p_halt) else $error("halt missed"); // R12

   property p_ten_er;
      (rise_en && !speed_100_in) |=> !tx_word_out.halt && tx_word_out.nib == $past(txd_in);
   endproperty
   a_ten_er: assert property (p_ten_er) else $error("tx error at 10M"); // R13

   property p_rx_fall;
      !$fell(rx_clk_out) |-> $stable(rxd_out) && $stable(rx_dv_out) && $stable(rx_er_out);
   endproperty
   a_rx_fall: assert property (p_rx_fall) else $error("rx changed off fall"); // R15

   property p_rx_er;
      $rose(rx_er_out) |-> rx_dv_out && $past(speed_100_in);
   endproperty
   a_rx_er: assert property (p_rx_er) else $error("bad rx error"); // R16

   property p_nolink;
      !link_up_in |=> !crs_out && !col_out && !rx_dv_out && !rx_er_out;
   endproperty
   a_nolink: assert property (p_nolink) else $error("status without link"); // R18

   property p_md_own;
      mdio_oe_out |-> st.rd && (st.ms == pmp_pkg::MS_DATA);
   endproperty
   a_md_own: assert property (p_md_own) else $error("mdio driven outside read"); // R3

   c_hb: cover property (col_out && !rx_carrier_in && !st.tx_act);
   c_col: cover property (col_out && st.tx_act && rx_carrier_in);
   c_md_read: cover property ($rose(mdio_oe_out));
   c_halt: cover property (tx_valid_out && tx_word_out.halt);
endmodule : pmp_port

// File: bench/pmp_mac_model.sv
// mac and station manager model facing the phy mii port
`timescale 1ns/1ps
module pmp_mac_model (
   // clock
   input  wire logic  clock_in,
   // mii transmit
   input  wire logic  tx_clk_in,
   output logic [3:0] txd_out,
   output logic       tx_en_out,
   output logic       tx_er_out,
   // management, drv 1 means released
   input  wire logic  mdio_line_in,
   output logic       mdc_out,
   output logic       mdio_drv_out
);
   logic [5:0] txq[$];
   logic       clk_q;

   initial begin
      {tx_en_out, tx_er_out, txd_out} = 6'h00;
      clk_q = 1'h0;
      mdc_out = 1'h0;
      mdio_drv_out = 1'h1;
   end

   // one queued word per transmit clock, changed just after the rise
   always @(posedge clock_in) begin
      clk_q <= tx_clk_in;
      if (tx_clk_in && !clk_q) begin
         if (txq.size() > 0) begin
            {tx_en_out, tx_er_out, txd_out} <= txq.pop_front();
         end else begin
            {tx_en_out, tx_er_out, txd_out} <= {2'h0, ~txd_out};
         end
      end
   end

   // one management bit, 5 cycles low then 5 high: 10 MHz
   task automatic mbit(input logic drv, input logic b, output logic s);
      mdio_drv_out <= drv ? b : 1'h1;
      repeat (5) @(posedge clock_in);
      mdc_out <= 1'h1;
      @(negedge clock_in);
      s = mdio_line_in;
      repeat (5) @(posedge clock_in);
      mdc_out <= 1'h0;
   endtask : mbit

   // read frame: header sent, then turnaround and data sampled
   task automatic mread(input logic [4:0] phy, input logic [4:0] rg,
                        output logic [17:0] got);
      logic [45:0] hdr;
      logic        s;
      hdr = {32'hFFFFFFFF, 4'h6, phy, rg};
      for (int i = 45; i >= 0; i--) mbit(1'h1, hdr[i], s);
      for (int i = 17; i >= 0; i--) begin
         mbit(1'h0, 1'h1, s);
         got[i] = s;
      end
      mbit(1'h0, 1'h1, s);
   endtask : mread
endmodule : pmp_mac_model

// File: bench/tb_pmp_port.sv
// self-checking bench of the phy mii port
`timescale 1ns/1ps
module tb_pmp_port;
   logic                  clock_in, rst_n_in, spd, fdx, link, hb, carrier, rx_valid;
   logic [3:0]            txd, rxd;
   logic                  tx_en, tx_er, mdc, sme_lvl, mdio_o, mdio_oe, tx_valid, rx_ready;
   logic                  tx_clk, rx_clk, rx_dv, rx_er, crs, col, tx_q, rx_q;
   logic [5:0]            rx_prev;
   pmp_pkg::pmp_tx_word_t tx_word;
   pmp_pkg::pmp_rx_word_t rx_word, e;
   pmp_pkg::pmp_rx_word_t exp_q[$];
   int                    err_total, cmp_count;
   wire logic mdio_line = (mdio_oe ? mdio_o : 1'h1) & sme_lvl;

   always #5 clock_in = ~clock_in;

   pmp_port pmp_port_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .speed_100_in(spd),
      .full_duplex_in(fdx), .link_up_in(link), .heartbeat_en_in(hb), .phy_addr_in(5'h0B),
      .txd_in(txd), .tx_en_in(tx_en), .tx_er_in(tx_er), .tx_clk_out(tx_clk),
      .rxd_out(rxd), .rx_dv_out(rx_dv), .rx_er_out(rx_er), .rx_clk_out(rx_clk),
      .crs_out(crs), .col_out(col), .mdc_in(mdc), .mdio_in(mdio_line),
      .mdio_out(mdio_o), .mdio_oe_out(mdio_oe), .tx_word_out(tx_word),
      .tx_valid_out(tx_valid), .rx_word_in(rx_word), .rx_valid_in(rx_valid),
      .rx_ready_out(rx_ready), .rx_carrier_in(carrier));

   pmp_mac_model pmp_mac_model_i (.clock_in(clock_in), .tx_clk_in(tx_clk), .txd_out(txd),
      .tx_en_out(tx_en), .tx_er_out(tx_er), .mdio_line_in(mdio_line), .mdc_out(mdc),
      .mdio_drv_out(sme_lvl));

   // -------------------------------------------------------------------
   // checking and closing
   // -------------------------------------------------------------------
   task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : summarize

   task automatic tmo();
      err_total++;
      $display("[ERR] %0t wait ran out", $time);
      summarize();
   endtask : tmo

   task automatic cyc(input int n);
      repeat (n) @(posedge clock_in);
   endtask : cyc

   // line words at each transmit rise, receive nibbles at each fall
   always @(negedge clock_in) begin
      if (tx_clk && !tx_q) begin
         chk({tx_valid, tx_word}, {tx_en, spd & tx_en & tx_er, txd}, "tx word");
      end
      if (!rx_clk && rx_q && rx_dv) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 5'h1F;
         chk({rx_er, rxd}, {e.err & spd, e.nib}, "rx nibble");
      end else if (rx_q === rx_clk) begin
         chk({rx_dv, rx_er, rxd}, rx_prev, "rx held");
      end
      tx_q = tx_clk;
      rx_q = rx_clk;
      rx_prev = {rx_dv, rx_er, rxd};
   end

   // -------------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------------
   task automatic s_clock(input logic s);
      int   hi, rises;
      logic p;
      spd <= s;
      cyc(100);
      hi = 0;
      rises = 0;
      p = tx_clk;
      repeat (400) begin
         @(negedge clock_in);
         hi += tx_clk;
         rises += (tx_clk && !p);
         p = tx_clk;
         chk(rx_clk, tx_clk, "rx clock");
      end
      chk(18'(hi), 18'd200, "duty");
      chk(18'(rises), s ? 18'd100 : 18'd10, "rate");
      @(posedge clock_in);
   endtask : s_clock

   task automatic wait_rise(input int n);
      logic p;
      int   lim;
      p = tx_clk;
      lim = 50 * n;
      for (int t = 0; t < lim && n > 0; t++) begin
         @(negedge clock_in);
         if (tx_clk && !p) n--;
         p = tx_clk;
      end
      if (n > 0) tmo();
   endtask : wait_rise

   task automatic s_tx(input logic s, input logic f, input logic h);
      int n;
      spd <= s;
      fdx <= f;
      hb <= h;
      cyc(50);
      for (int i = 0; i < 6; i++) begin
         pmp_mac_model_i.txq.push_back({1'h1, 1'(i % 2), 4'(i * 3)});
      end
      wait_rise(3);
      chk(crs, !f, "crs by transmit");
      @(posedge clock_in);
      carrier <= 1'h1;
      cyc(4);
      chk({crs, col}, {1'h1, !f}, "overlap");
      carrier <= 1'h0;
      cyc(3);
      n = 0;
      repeat (600) begin
         @(negedge clock_in);
         n += col;
      end
      chk(18'(n), (!s && !f && h) ? 18'h064 : 18'h000, "heartbeat");
      @(posedge clock_in);
   endtask : s_tx

   task automatic s_rx(input logic s);
      int refused, t;
      spd <= s;
      refused = 0;
      @(posedge clock_in);
      for (int i = 0; i < 12; i++) begin
         rx_word <= {1'(i % 3 == 0), 4'(i + 3)};
         rx_valid <= 1'h1;
         for (t = 0; t < 100; t++) begin
            @(negedge clock_in);
            if (rx_ready) break;
            refused++;
            @(posedge clock_in);
         end
         if (t == 100) tmo();
         exp_q.push_back(rx_word);
         @(posedge clock_in);
      end
      rx_valid <= 1'h0;
      for (t = 0; t < 800 && exp_q.size() > 0; t++) @(posedge clock_in);
      cyc(2);
      chk(18'(exp_q.size()), 18'd0, "rx drained");
      chk(rx_ready, 1'h1, "room again");
      chk(18'(refused > 2), 18'h001, "fifo refusal");
   endtask : s_rx

   task automatic s_mgmt();
      logic [17:0] got;
      @(posedge clock_in);
      pmp_mac_model_i.mread(5'h0B, 5'h01, got);
      chk(got, {2'h2, 12'h000, hb, fdx, spd, link}, "mgmt read");
      chk(mdio_oe, 1'h0, "mdio released");
      pmp_mac_model_i.mread(5'h0C, 5'h01, got);
      chk(got, 18'h3FFFF, "other address");
   endtask : s_mgmt

   // -------------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------------
   initial begin
      clock_in = 1'h0;
      rst_n_in = 1'h0;
      {spd, fdx, link, hb, carrier, rx_valid} = 6'h22;
      rx_word = 5'h00;
      {tx_q, rx_q, rx_prev} = 8'h00;
      err_total = 0;
      cmp_count = 0;
      cyc(16);
      chk({crs, col, rx_dv, rx_er, tx_clk, mdio_oe, tx_valid, rx_ready}, 8'h01, "reset");
      rst_n_in <= 1'h1;
      cyc(20);
      chk({crs, col, rx_dv, rx_er}, 4'h0, "no link");
      carrier <= 1'h0;
      link <= 1'h1;
      s_clock(1'h1);
      s_clock(1'h0);
      s_tx(1'h1, 1'h0, 1'h1);
      s_tx(1'h0, 1'h0, 1'h1);
      s_tx(1'h0, 1'h0, 1'h0);
      s_tx(1'h0, 1'h1, 1'h1);
      s_tx(1'h1, 1'h1, 1'h1);
      s_rx(1'h0);
      s_rx(1'h1);
      s_mgmt();
      summarize();
   end
endmodule : tb_pmp_port
